// ---- rtl/awf_pkg.sv ----
// Constants for the AND-accumulator-with-file execution block.
// Assumes a single core clock and a data memory with one-cycle reads.
package awf_pkg;
  // ==========================================================
  // Instruction encoding
  localparam logic [5:0] AWF_OPCODE = 6'h05;
  localparam int AWF_OP_HI = 15;
  localparam int AWF_OP_LO = 10;
  localparam int AWF_D_POS = 9;
  localparam int AWF_A_POS = 8;
  // ==========================================================
  // Addressing
  localparam logic [7:0] AWF_IDX_LIMIT = 8'h5F;
  localparam logic [7:0] AWF_ACC_SPLIT = 8'h60;
  localparam logic [3:0] AWF_ACC_HI_BANK = 4'hF;
  localparam logic [3:0] AWF_ACC_LO_BANK = 4'h0;
  // ==========================================================
  // Reset values
  localparam logic [7:0] AWF_W_RST = 8'h00;
  localparam logic [11:0] AWF_ADDR_RST = 12'h000;
  // Status flag positions in the two-bit flag output
  localparam int AWF_FLAG_Z = 0;
  localparam int AWF_FLAG_N = 1;

  typedef enum logic [1:0] {AWF_DECODE, AWF_READ, AWF_WRITE} awf_phase_e;

  // Address formation, shared by the address unit
  function automatic logic [11:0] awf_addr(input logic a_bit, input logic ext_en,
                                           input logic [7:0] f, input logic [3:0] bank,
                                           input logic [11:0] idx_base);
    if (a_bit) begin
      awf_addr = {bank, f};
    end else if (ext_en && (f <= AWF_IDX_LIMIT)) begin
      awf_addr = idx_base + {4'h0, f};
    end else if (f < AWF_ACC_SPLIT) begin
      awf_addr = {AWF_ACC_LO_BANK, f};
    end else begin
      awf_addr = {AWF_ACC_HI_BANK, f};
    end
  endfunction
endpackage

// ---- rtl/awf_addr_if.sv ----
// Address request and answer between the executor and its address unit.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
interface awf_addr_if;
  logic a_bit;
  logic ext_en;
  logic [7:0] f;
  logic [3:0] bank;
  logic [11:0] idx_base;
  logic [11:0] addr;
  modport req (output a_bit, output ext_en, output f, output bank, output idx_base,
               input addr);
  modport unit (input a_bit, input ext_en, input f, input bank, input idx_base,
                output addr);
endinterface

// ---- rtl/awf_addr_unit.sv ----
// Data address former for byte-oriented operands.
// Assumes the executor holds its request stable while it reads the answer.
`timescale 1ns/10ps
module awf_addr_unit
  import awf_pkg::*;
(
  awf_addr_if.unit port_if
);
  // ==========================================================
  // Combinational address formation
  always_comb begin
    port_if.addr = awf_addr(port_if.a_bit, port_if.ext_en, port_if.f, port_if.bank,
                            port_if.idx_base);
  end
endmodule // awf_addr_unit

// ---- rtl/awf_exec.sv ----
// Execution stage for the AND-accumulator-with-file instruction.
// Assumes a data memory that answers a read in the next clock.
`timescale 1ns/10ps
module awf_exec
  import awf_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic ext_en_in,
  input wire logic [3:0] bank_number_register_in,
  input wire logic [11:0] index_base_in,
  input wire logic [7:0] mem_rdata_in,
  output logic [11:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  output logic [7:0] w_out,
  output logic [1:0] flags_out,
  output logic flags_wr_out,
  output logic busy_out,
  output logic done_out
);
  // ==========================================================
  // Address unit
  // Operand fields travel to the address former as one bundle,
  // so the access-bank, banked and indexed forms live in one place.
  awf_addr_if addr_if ();

  awf_addr_unit u_addr (
    .port_if(addr_if)
  );

  // ==========================================================
  // Declarations
  // Sequencer state
  awf_phase_e phase_q;
  awf_phase_e phase_d;
  logic busy_q;
  logic busy_d;
  logic rd_q;
  logic rd_d;
  logic done_q;
  logic done_d;

  // Instruction fields kept from the take edge
  logic dest_q;
  logic dest_d;
  logic [11:0] addr_q;
  logic [11:0] addr_d;

  // Data path state
  logic [7:0] w_q;
  logic [7:0] w_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic wr_q;
  logic wr_d;

  // Status flags and their update strobe
  logic [1:0] flags_q;
  logic [1:0] flags_d;
  logic fwr_q;
  logic fwr_d;

  // Combinational helpers
  logic [7:0] result;
  logic is_and_file;
  logic take;
  logic in_read;

  // ==========================================================
  // Decode
  // Only the opcode field is matched; the operand bits are free.
  assign is_and_file = instr_valid_in && (instr_in[AWF_OP_HI:AWF_OP_LO] == AWF_OPCODE);
  // Requests seen while busy are dropped, never queued
  assign take = is_and_file && (phase_q == AWF_DECODE);
  assign in_read = (phase_q == AWF_READ);

  // Operand fields for the address former
  assign addr_if.a_bit = instr_in[AWF_A_POS];
  assign addr_if.ext_en = ext_en_in;
  assign addr_if.f = instr_in[7:0];
  assign addr_if.bank = bank_number_register_in;
  assign addr_if.idx_base = index_base_in;

  // The memory answers in the read phase; the AND is purely combinational
  assign result = w_q & mem_rdata_in;

  // ==========================================================
  // Sequencer
  // Decode, read, write: three phases inside one instruction slot.
  // A new instruction is only looked at in the decode phase.
  always_comb begin
    phase_d = phase_q;
    rd_d = 1'b0;
    done_d = 1'b0;
    case (phase_q)
      AWF_DECODE: begin
        if (take) begin
          rd_d = 1'b1;
          phase_d = AWF_READ;
        end
      end
      AWF_READ: begin
        // Result is routed at the end of this phase
        phase_d = AWF_WRITE;
        done_d = 1'b1;
      end
      AWF_WRITE: begin
        // Write lands here; back to decode for the next instruction
        phase_d = AWF_DECODE;
      end
      default: begin
        phase_d = AWF_DECODE;
      end
    endcase
    // Busy is registered so the output comes from a flop
    busy_d = (phase_d != AWF_DECODE);
  end

  // Sequencer registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_q <= AWF_DECODE;
      busy_q <= 1'b0;
      rd_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      busy_q <= busy_d;
      rd_q <= rd_d;
      done_q <= done_d;
    end
  end

  // ==========================================================
  // Instruction fields
  // The address is frozen at take, so the caller may change the
  // operand bits while the instruction runs.
  always_comb begin
    dest_d = dest_q;
    addr_d = addr_q;
    if (take) begin
      dest_d = instr_in[AWF_D_POS];
      addr_d = addr_if.addr;
    end
  end

  // Field registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      dest_q <= 1'b1;
      addr_q <= AWF_ADDR_RST;
    end else begin
      dest_q <= dest_d;
      addr_q <= addr_d;
    end
  end

  // ==========================================================
  // Data path
  // Exactly one destination is written: the accumulator or memory.
  always_comb begin
    w_d = w_q;
    wdata_d = wdata_q;
    wr_d = 1'b0;
    if (in_read) begin
      if (dest_q) begin
        wr_d = 1'b1;
        wdata_d = result;
      end else begin
        w_d = result;
      end
    end
  end

  // Data path registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      w_q <= AWF_W_RST;
      wdata_q <= AWF_W_RST;
      wr_q <= 1'b0;
    end else begin
      w_q <= w_d;
      wdata_q <= wdata_d;
      wr_q <= wr_d;
    end
  end

  // ==========================================================
  // Status flags
  // Only negative and zero move; the rest of status is left alone
  // by the core, which watches the strobe to merge them.
  always_comb begin
    flags_d = flags_q;
    fwr_d = 1'b0;
    if (in_read) begin
      flags_d[AWF_FLAG_Z] = (result == 8'h00);
      flags_d[AWF_FLAG_N] = result[7];
      fwr_d = 1'b1;
    end
  end

  // Flag registers
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_q <= 2'h0;
      fwr_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      fwr_q <= fwr_d;
    end
  end

  // ==========================================================
  // Outputs
  // Every output is a flop, so callers see no decode glitches.
  assign mem_addr_out = addr_q;
  assign mem_rd_out = rd_q;
  assign mem_wr_out = wr_q;
  assign mem_wdata_out = wdata_q;
  assign w_out = w_q;
  assign flags_out = flags_q;
  assign flags_wr_out = fwr_q;
  assign done_out = done_q;
  assign busy_out = busy_q;
endmodule // awf_exec

// ---- bench/awf_exec_asserts.sv ----
// Checker for the AND-with-file executor.
// Assumes it is bound to awf_exec and sees only its ports.
`timescale 1ns/10ps
// ==========
// Checker
module awf_exec_asserts
  import awf_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic ext_en_in,
  input wire logic [3:0] bank_number_register_in,
  input wire logic [11:0] index_base_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [11:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic [7:0] w_out,
  input wire logic [1:0] flags_out,
  input wire logic flags_wr_out,
  input wire logic busy_out,
  input wire logic done_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Take condition and expected address, formed here independently
  wire tk = !busy_out && instr_valid_in && instr_in[15:10] == AWF_OPCODE;
  wire ix = ext_en_in && !instr_in[8] && instr_in[7:0] <= 8'h5F;
  wire [3:0] acc_bank = (instr_in[7:0] < 8'h60) ? 4'h0 : 4'hF;
  wire [11:0] ea = instr_in[8] ? {bank_number_register_in, instr_in[7:0]} : ix ?
    index_base_in + {4'h0, instr_in[7:0]} : {acc_bank, instr_in[7:0]};
  rd_take_a: assert property (tk |=> mem_rd_out) else $error("no read");
  rd_once_a: assert property (mem_rd_out |=> !mem_rd_out && done_out && flags_wr_out)
    else $error("bad sequence");
  addr_bank_a: assert property (tk && instr_in[8] |=> mem_addr_out == $past(ea))
    else $error("bank address");
  addr_acc_a: assert property (tk && !instr_in[8] && !ix |=> mem_addr_out == $past(ea))
    else $error("access address");
  addr_idx_a: assert property (tk && ix |=> mem_addr_out == $past(ea))
    else $error("indexed address");
  wr_back_a: assert property (done_out && $past(instr_in[9], 2) |-> mem_wr_out &&
    mem_wdata_out == ($past(w_out) & $past(mem_rdata_in))) else $error("write back");
  w_load_a: assert property (done_out && !$past(instr_in[9], 2) |-> !mem_wr_out &&
    w_out == ($past(w_out) & $past(mem_rdata_in))) else $error("accumulator load");
  flag_set_a: assert property (flags_wr_out |-> flags_out ==
    {$past(w_out[7] & mem_rdata_in[7]), $past(w_out & mem_rdata_in) == 8'h00}) else $error("flags");
  cover property (done_out && mem_wr_out);
  cover property (done_out && !mem_wr_out);
  cover property (tk && ix);
endmodule // awf_exec_asserts
bind awf_exec awf_exec_asserts u_chk (.*);

// ---- bench/tb_top.sv ----
// Self-checking bench for the AND-with-file executor.
// Assumes the executor and its package are compiled first.
`timescale 1ns/10ps
// ==========
// Bench
module tb_top
  import awf_pkg::*;
;
  logic mclk_in, rst_in, instr_valid_in, ext_en_in, mem_rd_out, mem_wr_out;
  logic flags_wr_out, busy_out, done_out;
  logic [15:0] instr_in;
  logic [3:0] bank_number_register_in;
  logic [11:0] index_base_in, mem_addr_out;
  logic [7:0] mem_rdata_in, mem_wdata_out, w_out, r;
  logic [1:0] flags_out;
  int n_errors, checks_done;
  awf_exec DUT (.*);
  // Shared compare and verdict
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One instruction; accumulator stays 00, so every result is 00
  task automatic op(input logic [9:0] df, input logic ext, input logic [11:0] ea);
    int i;
    instr_valid_in = 1; instr_in = {AWF_OPCODE, df}; ext_en_in = ext;
    @(posedge mclk_in); #1;
    instr_valid_in = 0;
    chk("read", mem_rd_out, 1);
    chk("address", mem_addr_out, ea);
    chk("busy", busy_out, 1);
    i = 0;
    while (done_out !== 1'b1) begin
      @(posedge mclk_in); #1;
      i++;
      if (i > 4) begin n_errors++; final_report; end
    end
    r = 8'h00 & mem_rdata_in;
    chk("latency", i, 1);
    chk("flag strobe", flags_wr_out, 1);
    chk("write", mem_wr_out, df[9]);
    chk("result", df[9] ? mem_wdata_out : w_out, r);
    chk("flags", flags_out, {r[7], r == 8'h00});
    @(posedge mclk_in); #1;
  endtask
  // Foreign opcode, then a request held while busy
  task automatic refuse;
    instr_valid_in = 1; instr_in = 16'h0000;
    @(posedge mclk_in); #1;
    chk("foreign", mem_rd_out, 0);
    instr_in = {AWF_OPCODE, 10'h312};
    @(posedge mclk_in); #1;
    chk("taken", mem_rd_out, 1);
    repeat (2) @(posedge mclk_in);
    #1;
    instr_valid_in = 0;
    chk("ignored", mem_rd_out, 0);
    chk("idle again", busy_out, 0);
    repeat (2) @(posedge mclk_in);
  endtask
  initial begin mclk_in = 0; forever #10 mclk_in = ~mclk_in; end
  initial begin
    n_errors = 0; checks_done = 0; rst_in = 1; instr_valid_in = 0; instr_in = 16'h0000;
    ext_en_in = 0; bank_number_register_in = 4'hA; index_base_in = 12'h3F0; mem_rdata_in = 8'hC2;
    repeat (10) @(posedge mclk_in);
    #1 rst_in = 0;
    chk("reset w", w_out, 12'h000);
    op(10'h25F, 0, 12'h05F);
    op(10'h060, 0, 12'hF60);
    op(10'h312, 1, 12'hA12);
    op(10'h25F, 1, 12'h44F);
    op(10'h060, 1, 12'hF60);
    refuse;
    final_report;
  end
endmodule // tb_top
